/* File: rtl/l2c_car.v */
`timescale 1ns/10ps
`include "l2c_defines.vh"

// separate unit cache
// One instance serves one compute unit; nothing is shared between instances.
module l2c_car #(
   parameter         WAYS      = 16,
   parameter         WORDS     = 16,
   parameter [31:0]  FILL_DATA = 32'h0
) (
   input  wire        mclk_i,
   input  wire        rst_i,
   input  wire        req_i,
   input  wire [47:0] req_addr_i,
   input  wire        req_we_i,
   input  wire        req_fetch_i,
   input  wire [1:0]  req_mtype_i,
   input  wire [3:0]  req_be_i,
   input  wire [31:0] req_wdata_i,
   output reg         req_ready_o,
   output reg         resp_valid_o,
   output reg  [31:0] resp_rdata_o,
   output reg         resp_err_o,
   output reg         resp_hit_o,
   input  wire [7:0]  reg_addr_i,
   input  wire [31:0] reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output reg  [31:0] reg_rdata_o,
   output reg         way_lock_enable_o,
   output reg         special_feature_disable_o,
   output reg         spec_tlb_reload_disable_o,
   output reg         hw_prefetch_disable_o,
   output reg         invalidate_writes_back_o
);

   // Sets are sized for the larger mode; the smaller mode uses the low half only.
   localparam SETS  = 1 << `L2C_IDX_W;
   localparam WAY_W = $clog2(WAYS);
   localparam DA_W  = `L2C_IDX_W + WAY_W + `L2C_WORD_W;
   localparam TA_W  = `L2C_IDX_W + WAY_W;

   // Tag, data and line state live in flip-flops indexed by set and way.
   reg [`L2C_TAG_W-1:0]  tag_mem [0:SETS*WAYS-1];
   reg [31:0]            dat_mem [0:SETS*WAYS*WORDS-1];
   reg [WAYS-1:0]        vld_r   [0:SETS-1];
   reg [WAYS-1:0]        dty_r   [0:SETS-1];

   // A single lookup state keeps every answer at a fixed two cycles.
   reg                   st_r;
   reg [47:0]            a_r;
   reg                   we_r;
   reg                   fetch_r;
   reg [1:0]             mt_r;
   reg [3:0]             be_r;
   reg [31:0]            wd_r;
   reg [3:0]             flw_r;
   reg                   size_r;
   reg [31:0]            evcnt_r;
   reg [WAY_W-1:0]       rr_r;
   reg [WAY_W-1:0]       last_way_r;
   reg                   last_hit_r;

   reg [`L2C_IDX_W-1:0]  idx;
   reg [`L2C_TAG_W-1:0]  tag;
   reg [`L2C_WORD_W-1:0] word;
   reg                   hit;
   reg [WAY_W-1:0]       hit_way;
   reg                   inv_found;
   reg [WAY_W-1:0]       inv_way;
   reg [WAY_W-1:0]       vic_way;
   reg [WAY_W-1:0]       use_way;
   reg [WAYS-1:0]        allow;
   reg                   err;
   reg [31:0]            old_word;
   reg [31:0]            wmerge;
   reg [3:0]             flw_nxt;
   reg [31:0]            rd_nxt;
   integer               w;
   integer               b;
   integer               s;
   integer               f;

   wire                  is_wb   = (mt_r == `L2C_MT_WB);
   // Only storage accesses free of a type error touch the arrays; refused ones just report.
   wire                  do_wb   = (st_r == `L2C_ST_LOOK) && is_wb && !err;
   wire [TA_W-1:0]       taddr   = {idx, use_way};
   wire [DA_W-1:0]       daddr   = {idx, use_way, word};
   // The invalidate command acts in the cycle of its write and leaves no state behind.
   wire                  inv_cmd = reg_wr_i && (reg_addr_i == `L2C_REG_CMD) && reg_wdata_i[`L2C_CMD_INVAL];
   wire                  ctrl_wr = reg_wr_i && (reg_addr_i == `L2C_REG_CTRL);
   wire                  ev_wr   = reg_wr_i && (reg_addr_i == `L2C_REG_EVCNT);
   // Only dirty victims count; losing a clean line loses no data.
   wire                  ev_inc  = do_wb && !hit && !inv_found && vld_r[idx][vic_way] && dty_r[idx][vic_way];

   always @* begin
      idx  = {1'b0, a_r[`L2C_IDX1M_HI:`L2C_IDX_LO]};
      tag  = a_r[`L2C_ADDR_HI:`L2C_TAG1M_LO];
      // Tags do not carry the size mode, so software changes the size only while every line is invalid.
      // 2 MB split
      if (size_r) begin
         idx = a_r[`L2C_IDX2M_HI:`L2C_IDX_LO];
         tag = {1'b0, a_r[`L2C_ADDR_HI:`L2C_TAG2M_LO]};
      end
      word = a_r[`L2C_WORD_HI:`L2C_WORD_LO];
      hit       = 1'b0;
      hit_way   = {WAY_W{1'b0}};
      inv_found = 1'b0;
      inv_way   = {WAY_W{1'b0}};
      allow     = {WAYS{1'b0}};
      for (w = 0; w < WAYS; w = w + 1) begin
         allow[w] = !way_lock_enable_o || (w < flw_r);
         // A hit may sit in a locked way; locking only limits where new lines go.
         if (vld_r[idx][w] && (tag_mem[{idx, w[WAY_W-1:0]}] == tag)) begin
            hit     = 1'b1;
            hit_way = w[WAY_W-1:0];
         end
         if (allow[w] && !vld_r[idx][w]) begin
            inv_found = 1'b1;
            inv_way   = w[WAY_W-1:0];
         end
      end
      // Way 0 is always below the lowest legal lock point, so it is a safe fallback victim.
      vic_way = allow[rr_r] ? rr_r : {WAY_W{1'b0}};
      use_way = hit ? hit_way : (inv_found ? inv_way : vic_way);
      err = (is_wb && fetch_r) || ((mt_r == `L2C_MT_WPIO) && we_r);
      old_word = hit ? dat_mem[daddr] : FILL_DATA;
      wmerge = old_word;
      for (b = 0; b < 4; b = b + 1) begin
         if (be_r[b]) begin
            wmerge[8*b +: 8] = wd_r[8*b +: 8];
         end
      end
   end

   always @(posedge mclk_i) begin
      if (do_wb) begin
         if (!hit) begin
            tag_mem[taddr] <= tag;
            for (f = 0; f < WORDS; f = f + 1) begin
               dat_mem[{idx, use_way, f[`L2C_WORD_W-1:0]}] <= FILL_DATA;
            end
         end
         if (we_r) begin
            dat_mem[daddr] <= wmerge;
         end
      end
   end

   always @(posedge mclk_i) begin
      if (rst_i || inv_cmd) begin
         // Invalidate drops everything without writeback; the teardown order is software's job.
         for (s = 0; s < SETS; s = s + 1) begin
            vld_r[s] <= {WAYS{1'b0}};
            dty_r[s] <= {WAYS{1'b0}};
         end
      end
      // A fill in the same cycle as an invalidate survives it: the set wins over the clear.
      if (!rst_i && do_wb) begin
         vld_r[idx][use_way] <= 1'b1;
         if (we_r) begin
            dty_r[idx][use_way] <= 1'b1;
         end else if (!hit) begin
            dty_r[idx][use_way] <= 1'b0;
         end
      end
   end

   always @* begin
      flw_nxt = reg_wdata_i[`L2C_CTRL_FLW_HI:`L2C_CTRL_FLW_LO];
      // A lower value would hand storage ways to locking, so it is raised to the floor.
      // first locked way floor
      if (flw_nxt < `L2C_FLW_MIN) begin
         flw_nxt = `L2C_FLW_MIN;
      end
      case (reg_addr_i)
         `L2C_REG_CTRL: begin
            rd_nxt = 32'h0;
            rd_nxt[`L2C_CTRL_LOCK]                  = way_lock_enable_o;
            rd_nxt[`L2C_CTRL_FLW_HI:`L2C_CTRL_FLW_LO] = flw_r;
            rd_nxt[`L2C_CTRL_SIZE]                  = size_r;
            rd_nxt[`L2C_CTRL_SSD]                   = special_feature_disable_o;
            rd_nxt[`L2C_CTRL_TLB]                   = spec_tlb_reload_disable_o;
            rd_nxt[`L2C_CTRL_PF]                    = hw_prefetch_disable_o;
            rd_nxt[`L2C_CTRL_INVWB]                 = invalidate_writes_back_o;
         end
         `L2C_REG_ID:    rd_nxt = {(size_r ? `L2C_SIZE_2M : `L2C_SIZE_1M), `L2C_ASSOC_16, 4'h0, `L2C_LINE_BYTES};
         `L2C_REG_EVCNT: rd_nxt = evcnt_r;
         `L2C_REG_STAT:  rd_nxt = {{(31-WAY_W-1){1'b0}}, last_hit_r, last_way_r, req_ready_o};
         default:        rd_nxt = 32'h0;
      endcase
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         st_r                      <= `L2C_ST_IDLE;
         a_r                       <= 48'h0;
         we_r                      <= 1'b0;
         fetch_r                   <= 1'b0;
         mt_r                      <= `L2C_MT_UC;
         be_r                      <= 4'h0;
         wd_r                      <= 32'h0;
         req_ready_o               <= 1'b1;
         resp_valid_o              <= 1'b0;
         resp_rdata_o              <= 32'h0;
         resp_err_o                <= 1'b0;
         resp_hit_o                <= 1'b0;
         rr_r                      <= {WAY_W{1'b0}};
         last_way_r                <= {WAY_W{1'b0}};
         last_hit_r                <= 1'b0;
      end else begin
         // The response pulse lasts one cycle; data and flags hold until the next answer.
         resp_valid_o <= 1'b0;
         case (st_r)
            `L2C_ST_IDLE: begin
               if (req_i) begin
                  st_r        <= `L2C_ST_LOOK;
                  a_r         <= req_addr_i;
                  we_r        <= req_we_i;
                  fetch_r     <= req_fetch_i;
                  mt_r        <= req_mtype_i;
                  be_r        <= req_be_i;
                  wd_r        <= req_wdata_i;
                  req_ready_o <= 1'b0;
               end
            end
            `L2C_ST_LOOK: begin
               st_r         <= `L2C_ST_IDLE;
               req_ready_o  <= 1'b1;
               resp_valid_o <= 1'b1;
               resp_err_o   <= err;
               resp_hit_o   <= do_wb && hit;
               // bypass for ROM type
               // Non-storage reads see whatever the idle memory path returns, here the fill value.
               resp_rdata_o <= (do_wb && hit && !we_r) ? old_word : FILL_DATA;
               if (do_wb) begin
                  last_way_r <= use_way;
                  last_hit_r <= hit;
                  // The victim pointer moves only on a real eviction, so invalid-way fills leave it alone.
                  if (!hit && !inv_found) begin
                     rr_r <= rr_r + {{(WAY_W-1){1'b0}}, 1'b1};
                  end
               end
            end
            default: begin
               st_r        <= `L2C_ST_IDLE;
               req_ready_o <= 1'b1;
            end
         endcase
      end
   end

   // Configuration bits are plain storage; the boot order around them is software's duty.
   always @(posedge mclk_i) begin
      if (rst_i) begin
         way_lock_enable_o         <= 1'b0;
         flw_r                     <= `L2C_FLW_RST;
         size_r                    <= 1'b0;
         special_feature_disable_o <= 1'b0;
         spec_tlb_reload_disable_o <= 1'b0;
         hw_prefetch_disable_o     <= 1'b0;
         invalidate_writes_back_o  <= `L2C_INVWB_RST;
      end else if (ctrl_wr) begin
         way_lock_enable_o         <= reg_wdata_i[`L2C_CTRL_LOCK];
         flw_r                     <= flw_nxt;
         size_r                    <= reg_wdata_i[`L2C_CTRL_SIZE];
         special_feature_disable_o <= reg_wdata_i[`L2C_CTRL_SSD];
         spec_tlb_reload_disable_o <= reg_wdata_i[`L2C_CTRL_TLB];
         hw_prefetch_disable_o     <= reg_wdata_i[`L2C_CTRL_PF];
         invalidate_writes_back_o  <= reg_wdata_i[`L2C_CTRL_INVWB];
      end
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         evcnt_r <= 32'h0;
      end else if (ev_inc) begin
         // A clear in the same cycle as a count keeps that count, so no victim goes unseen.
         evcnt_r <= ev_wr ? 32'h1 : evcnt_r + 32'h1;
      end else if (ev_wr) begin
         evcnt_r <= 32'h0;
      end
   end

   // Read data stand only in cycles after one with the read strobe high, so a late sampler sees zero rather than stale data.
   always @(posedge mclk_i) begin
      if (rst_i || !reg_rd_i) begin
         reg_rdata_o <= 32'h0;
      end else begin
         reg_rdata_o <= rd_nxt;
      end
   end

endmodule // l2c_car

/* File: rtl/l2c_defines.vh */
`ifndef L2C_DEFINES_VH
`define L2C_DEFINES_VH
// Behaviour
// - 1 MB: tag bits 47:16, index 15:6.
// - 2 MB: tag bits 47:17, index 16:6.
// - Low six address bits pick the byte.
// - Allocate invalid ways before evicting valid ones.
// - Highest-numbered invalid way wins, way 0 last.
// - Write-protect IO never allocates or evicts.
// - Fills to dead controller complete, data undefined.
// - Locking limits storage below first locked way.
// - Report size, associativity code, line size.
// - At least 512 KB and 14 ways usable.
// - Count dirty victims sent toward memory.
// - Write-back storage data only; ROM read and fetch.
// - Each compute unit owns a separate cache.

`define L2C_REG_CTRL      8'h00
`define L2C_REG_CMD       8'h04
`define L2C_REG_ID        8'h08
`define L2C_REG_EVCNT     8'h0c
`define L2C_REG_STAT      8'h10

`define L2C_CTRL_LOCK     0
`define L2C_CTRL_FLW_LO   4
`define L2C_CTRL_FLW_HI   7
`define L2C_CTRL_SIZE     8
`define L2C_CTRL_SSD      9
`define L2C_CTRL_TLB      10
`define L2C_CTRL_PF       11
`define L2C_CTRL_INVWB    12
`define L2C_CMD_INVAL     0

`define L2C_FLW_RST       4'hf
`define L2C_FLW_MIN       4'he
`define L2C_INVWB_RST     1'b1

`define L2C_MT_UC         2'h0
`define L2C_MT_WPIO       2'h1
`define L2C_MT_WB         2'h2

`define L2C_ASSOC_16      4'h8
`define L2C_LINE_BYTES    8'h40
`define L2C_SIZE_1M       16'h0400
`define L2C_SIZE_2M       16'h0800

`define L2C_ADDR_HI       47
`define L2C_TAG1M_LO      16
`define L2C_TAG2M_LO      17
`define L2C_IDX1M_HI      15
`define L2C_IDX2M_HI      16
`define L2C_IDX_LO        6
`define L2C_WORD_HI       5
`define L2C_WORD_LO       2
`define L2C_IDX_W         11
`define L2C_TAG_W         32
`define L2C_WORD_W        4

`define L2C_ST_IDLE       1'b0
`define L2C_ST_LOOK       1'b1
`endif

/* File: sim/l2c_car_properties.sv */
`timescale 1ns/10ps
`include "l2c_defines.vh"

module l2c_car_props #(
   parameter [31:0] FILL_DATA = 32'h0
) (
   input wire        mclk_i,
   input wire        rst_i,
   input wire        req_i,
   input wire        req_we_i,
   input wire        req_fetch_i,
   input wire [1:0]  req_mtype_i,
   input wire        req_ready_o,
   input wire        resp_valid_o,
   input wire [31:0] resp_rdata_o,
   input wire        resp_err_o,
   input wire        resp_hit_o,
   input wire [7:0]  reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [31:0] reg_rdata_o,
   input wire        way_lock_enable_o,
   input wire        special_feature_disable_o,
   input wire        spec_tlb_reload_disable_o,
   input wire        hw_prefetch_disable_o,
   input wire        invalidate_writes_back_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   wire [4:0] cfg = {invalidate_writes_back_o, hw_prefetch_disable_o, spec_tlb_reload_disable_o,
                     special_feature_disable_o, way_lock_enable_o};
   wire [4:0] wcfg = {reg_wdata_i[12:9], reg_wdata_i[0]};
   wire       ctrl_wr = reg_wr_i && reg_addr_i == `L2C_REG_CTRL;
   wire       ctrl_rd = reg_rd_i && reg_addr_i == `L2C_REG_CTRL;
   wire       taken = req_i && req_ready_o;
   sequence taken_s; taken; endsequence
   sequence answer_s; !req_ready_o ##1 (req_ready_o && resp_valid_o); endsequence

   ready_gap_a: assert property (taken_s |=> answer_s) else $error("core answer timing wrong");
   resp_cause_a: assert property (resp_valid_o |-> $past(taken, 2)) else $error("response without request");
   fetch_err_a: assert property (taken && req_fetch_i && req_mtype_i == `L2C_MT_WB |-> ##2 resp_err_o)
      else $error("fetch from storage type not refused");
   wpio_store_a: assert property (taken && req_we_i && req_mtype_i == `L2C_MT_WPIO |-> ##2 resp_err_o)
      else $error("store to rom type not refused");
   wpio_fill_a: assert property (taken && !req_we_i && req_mtype_i == `L2C_MT_WPIO
      |-> ##2 (!resp_hit_o && resp_rdata_o == FILL_DATA)) else $error("rom type access touched the cache");
   rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("read data not idle");
   id_code_a: assert property (reg_rd_i && reg_addr_i == `L2C_REG_ID |=> reg_rdata_o[15:0] == 16'h8040)
      else $error("associativity or line size wrong");
   cfg_write_a: assert property (ctrl_wr |=> cfg == $past(wcfg)) else $error("config bits not written");
   cfg_hold_a: assert property (!ctrl_wr |=> $stable(cfg)) else $error("config bits moved");
   flw_floor_a: assert property (ctrl_wr && reg_wdata_i[7:4] < `L2C_FLW_MIN ##[1:3] ctrl_rd
      |=> reg_rdata_o[7:4] == `L2C_FLW_MIN) else $error("first locked way below floor");
endmodule // l2c_car_props

bind l2c_car l2c_car_props #(.FILL_DATA(FILL_DATA)) i_props (.mclk_i, .rst_i, .req_i, .req_we_i, .req_fetch_i,
   .req_mtype_i, .req_ready_o, .resp_valid_o, .resp_rdata_o, .resp_err_o, .resp_hit_o, .reg_addr_i, .reg_wdata_i,
   .reg_wr_i, .reg_rd_i, .reg_rdata_o, .way_lock_enable_o, .special_feature_disable_o, .spec_tlb_reload_disable_o,
   .hw_prefetch_disable_o, .invalidate_writes_back_o);

/* File: sim/l2c_core_model.sv */
`timescale 1ns/10ps

module l2c_core_model (
   input  wire        mclk_i,
   output reg         req_o,
   output reg  [47:0] addr_o,
   output reg         we_o,
   output reg         fetch_o,
   output reg  [1:0]  mtype_o,
   output reg  [3:0]  be_o,
   output reg  [31:0] wdata_o,
   input  wire        ready_i,
   input  wire        valid_i,
   input  wire [31:0] rdata_i,
   input  wire        err_i,
   input  wire        hit_i
);
   initial begin
      req_o = 1'b0;
      addr_o = 48'h0;
      we_o = 1'b0;
      fetch_o = 1'b0;
      mtype_o = 2'h0;
      be_o = 4'hf;
      wdata_o = 32'h0;
   end

   // firmware discipline
   // Callers load before storing and never flush mid-use; t_alloc fills one line more per set than the usable ways to force an eviction.
   task access(input [47:0] a, input w, input f, input [1:0] m, input [3:0] s, input [31:0] d,
               output [31:0] q, output e, output h, output ok);
      integer k;
      begin
         @(posedge mclk_i);
         req_o <= 1'b1;
         addr_o <= a;
         we_o <= w;
         fetch_o <= f;
         mtype_o <= m;
         be_o <= s;
         wdata_o <= d;
         do @(posedge mclk_i); while (ready_i !== 1'b1);
         req_o <= 1'b0;
         addr_o <= ~a;
         wdata_o <= ~d;
         ok = 1'b0;
         for (k = 0; k < 4 && !ok; k = k + 1) begin
            @(posedge mclk_i);
            ok = valid_i === 1'b1;
         end
         q = rdata_i;
         e = err_i;
         h = hit_i;
      end
   endtask
endmodule // l2c_core_model

/* File: sim/testbench.sv */
`timescale 1ns/10ps
`include "l2c_defines.vh"

module testbench;
   localparam [31:0] FILL = 32'h5a5a_c3c3;
   reg         mclk_i, rst_i, rwr, rrd, e, h, ok;
   reg  [7:0]  ra;
   reg  [31:0] rwd, q;
   wire        req, we, fe, rdy, vld, err, hit;
   wire [47:0] addr;
   wire [1:0]  mt;
   wire [3:0]  be;
   wire [31:0] wd, rdat, rq;
   wire [4:0]  cfg;
   integer     n_errors, n_checks;

   l2c_car #(.FILL_DATA(FILL)) i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .req_addr_i(addr),
      .req_we_i(we), .req_fetch_i(fe), .req_mtype_i(mt), .req_be_i(be), .req_wdata_i(wd), .req_ready_o(rdy),
      .resp_valid_o(vld), .resp_rdata_o(rdat), .resp_err_o(err), .resp_hit_o(hit), .reg_addr_i(ra),
      .reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rq), .way_lock_enable_o(cfg[0]),
      .special_feature_disable_o(cfg[1]), .spec_tlb_reload_disable_o(cfg[2]), .hw_prefetch_disable_o(cfg[3]),
      .invalidate_writes_back_o(cfg[4]));
   l2c_core_model i_core (.mclk_i(mclk_i), .req_o(req), .addr_o(addr), .we_o(we), .fetch_o(fe), .mtype_o(mt),
      .be_o(be), .wdata_o(wd), .ready_i(rdy), .valid_i(vld), .rdata_i(rdat), .err_i(err), .hit_i(hit));

   task tally_and_finish;
      begin
         $display("checks %0d errors %0d", n_checks, n_errors);
         if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task reg_wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge mclk_i);
         rwr <= 1'b1;
         ra <= a;
         rwd <= d;
         @(posedge mclk_i);
         rwr <= 1'b0;
         rwd <= ~d;
      end
   endtask
   task rd_chk(input [7:0] a, input [31:0] x);
      begin
         @(posedge mclk_i);
         rrd <= 1'b1;
         ra <= a;
         @(posedge mclk_i);
         rrd <= 1'b0;
         @(posedge mclk_i);
         chk(rq, x);
      end
   endtask
   task ac_chk(input [47:0] a, input w, input f, input [1:0] m, input [31:0] d, input [31:0] xq, input [1:0] xeh);
      begin
         i_core.access(a, w, f, m, 4'hf, d, q, e, h, ok);
         chk({31'h0, ok}, 32'h1);
         chk({30'h0, e, h}, {30'h0, xeh});
         if (xeh[1] !== 1'b1)
            chk(q, xq);
      end
   endtask

   task t_reset;
      begin
         rd_chk(`L2C_REG_CTRL, 32'h0000_10f0);
         rd_chk(`L2C_REG_ID, 32'h0400_8040);
         rd_chk(8'h40, 32'h0);
         rd_chk(`L2C_REG_EVCNT, 32'h0);
         chk({27'h0, cfg}, 32'h10);
      end
   endtask
   task t_boot;
      begin
         reg_wr(`L2C_REG_CTRL, 32'h0000_0e31);
         rd_chk(`L2C_REG_CTRL, 32'h0000_0ee1);
         reg_wr(`L2C_REG_CTRL, 32'h0000_0ef1);
         rd_chk(`L2C_REG_CTRL, 32'h0000_0ef1);
         chk({27'h0, cfg}, 32'h0f);
      end
   endtask
   task t_alloc;
      integer i;
      begin
         for (i = 0; i < 15; i = i + 1) begin
            ac_chk({i[31:0], 16'h0140}, 0, 0, `L2C_MT_WB, 0, FILL, 2'b00);
            rd_chk(`L2C_REG_STAT, {27'h0, 4'he - i[3:0], 1'b1});
         end
         for (i = 0; i < 15; i = i + 1) begin
            ac_chk({i[31:0], 16'h0144}, 1, 0, `L2C_MT_WB, 32'h1000 + i, FILL, 2'b01);
            ac_chk({i[31:0], 16'h0144}, 0, 0, `L2C_MT_WB, 0, 32'h1000 + i, 2'b01);
            ac_chk({i[31:0], 16'h0148}, 0, 0, `L2C_MT_WB, 0, FILL, 2'b01);
         end
         rd_chk(`L2C_REG_EVCNT, 32'h0);
         ac_chk({32'd15, 16'h0140}, 0, 0, `L2C_MT_WB, 0, FILL, 2'b00);
         rd_chk(`L2C_REG_EVCNT, 32'h1);
      end
   endtask
   task t_bytes;
      begin
         i_core.access({32'h0, 16'h0144}, 1, 0, `L2C_MT_WB, 4'h5, 32'haabb_ccdd, q, e, h, ok);
         chk({29'h0, ok, e, h}, 32'h5);
         ac_chk({32'h0, 16'h0144}, 0, 0, `L2C_MT_WB, 0, 32'h00bb_10dd, 2'b01);
      end
   endtask
   task t_mtypes;
      begin
         ac_chk(48'h7_0240, 0, 0, `L2C_MT_WPIO, 0, FILL, 2'b00);
         ac_chk(48'h7_0240, 0, 1, `L2C_MT_WPIO, 0, FILL, 2'b00);
         ac_chk(48'h7_0240, 1, 0, `L2C_MT_WPIO, 32'h5a, FILL, 2'b10);
         ac_chk(48'h7_0240, 0, 1, `L2C_MT_WB, 0, FILL, 2'b10);
         ac_chk(48'h7_0240, 0, 0, `L2C_MT_WB, 0, FILL, 2'b00);
      end
   endtask
   task t_teardown;
      begin
         reg_wr(`L2C_REG_CMD, 32'h1);
         reg_wr(`L2C_REG_CTRL, 32'h0000_11f0);
         rd_chk(`L2C_REG_ID, 32'h0800_8040);
         chk({27'h0, cfg}, 32'h10);
         ac_chk(48'h1_0140, 0, 0, `L2C_MT_WB, 0, FILL, 2'b00);
         rd_chk(`L2C_REG_STAT, 32'h1f);
         ac_chk(48'h0_0140, 0, 0, `L2C_MT_WB, 0, FILL, 2'b00);
         rd_chk(`L2C_REG_STAT, 32'h1f);
         ac_chk(48'h1_0140, 0, 0, `L2C_MT_WB, 0, FILL, 2'b01);
      end
   endtask

   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   initial begin
      #20000;
      n_errors = n_errors + 1;
      tally_and_finish;
   end
   initial begin
      n_errors = 0;
      n_checks = 0;
      rst_i = 1'b1;
      rwr = 1'b0;
      rrd = 1'b0;
      ra = 8'h0;
      rwd = 32'h0;
      repeat (20) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_reset;
      t_boot;
      t_alloc;
      t_bytes;
      t_mtypes;
      t_teardown;
      tally_and_finish;
   end
endmodule // testbench
